// [sacp_ctrl.sv]
`timescale 1ns/1ps
`include "sacp_defs.svh"


module sacp_ctrl
    import sacp_pkg::*;
#(
    parameter int FIFO_DEPTH = `SACP_FIFO_DEPTH,
    parameter int SCLK_DIV = `SACP_SCLK_DIV
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire sacp_pins_t pins,
    output logic busy,
    output logic sample_hold,
    output logic power_reduced,
    output sacp_word_t dac_code,
    output sacp_word_t data_o,
    output sacp_word_t data_oe
);

localparam sacp_cnt_t ACQ_CYC = sacp_cnt_t'(`SACP_CYC_UP(`SACP_ACQ_NS));
localparam sacp_cnt_t STEP_CYC = sacp_cnt_t'(`SACP_CYC_UP(`SACP_STEP_NS));
localparam sacp_cnt_t OVR_CYC = sacp_cnt_t'(`SACP_CYC_UP(`SACP_OVR_NS));
localparam sacp_cnt_t DIV_CYC = sacp_cnt_t'(SCLK_DIV);
localparam sacp_bits_t RES_B = sacp_bits_t'(`SACP_RES);
localparam sacp_word_t MSB_ONE = sacp_word_t'(1) << (`SACP_RES - 1);

sacp_ctrl_st_t st_q;
sacp_ctrl_st_t st_d;
sacp_pins_t p;

logic bus_en;
logic ser;
logic ext;
logic intser;
logic imp;
logic cnv_fall;
logic sclk_rise;
logic acq_done;
logic acq_end;
logic start;
logic rd_busy;
logic pop;
logic fifo_in_ready;
logic fifo_out_valid;
logic fifo_empty;
sacp_word_t fifo_out_data;

function automatic logic sacp_fell(input logic was, input logic now);
    return was && !now;
endfunction : sacp_fell

// synchronisers reset to the idle pin levels, so no false enable or start edge follows reset
function automatic sacp_ctrl_st_t sacp_st_rst();
    sacp_ctrl_st_t v;
    sacp_pins_t idle;
    idle = '0;
    idle.cs_n = 1'b1;
    idle.rd_n = 1'b1;
    idle.convert_start_n = 1'b1;
    v = '0;
    v.s1 = idle;
    v.s2 = idle;
    v.prev = idle;
    return v;
endfunction : sacp_st_rst

localparam sacp_ctrl_st_t ST_RST = sacp_st_rst();

// p is the second synchroniser stage; the first is read by nothing else
assign p = st_q.s2;

assign bus_en = !p.cs_n && !p.rd_n;
assign ser = p.serial_parallel_select;
assign ext = ser && p.clock_source_select;
assign intser = ser && !p.clock_source_select;
assign imp = p.impulse && !p.warp;
assign cnv_fall = sacp_fell(st_q.prev.convert_start_n, p.convert_start_n);
assign sclk_rise = sacp_fell(p.sclk_pin, st_q.prev.sclk_pin);
assign acq_done = (st_q.acq_cnt >= ACQ_CYC);
assign acq_end = (st_q.acq_cnt == ACQ_CYC - 1'b1);
assign rd_busy = (st_q.bit_cnt != '0) && (st_q.bit_cnt < RES_B);

// power-down only blocks the start, never the running conversion; reset also aborts a running one
assign start = (st_q.state == SACP_ACQ) && !p.power_down_input && !p.reset_pin
    && ((acq_done && cnv_fall)
    || (imp && acq_end && !p.convert_start_n));

// hold the latched word while a parallel read or internal-clock shift is on
assign pop = fifo_out_valid && !(bus_en && !ser) && !(intser && st_q.sync);

sacp_fifo #(
    .W(`SACP_RES),
    .DEPTH(FIFO_DEPTH)
) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clear(p.reset_pin),
    .in_valid(st_q.state == SACP_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(st_q.sar),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data),
    .empty(fifo_empty)
);

always_comb begin
    logic shift;
    shift = 1'b0;
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.prev = st_q.s2;
    if (st_q.ovr_cnt != '0) begin
        st_d.ovr_cnt = st_q.ovr_cnt - 1'b1;
    end

    case (st_q.state)
        SACP_ACQ: begin
            if (!acq_done) begin
                st_d.acq_cnt = st_q.acq_cnt + 1'b1;
            end
            if (start) begin
                st_d.state = SACP_CONV;
                st_d.hold = 1'b1;
                st_d.step_cnt = '0;
                st_d.sar = '0;
                st_d.trial = MSB_ONE;
            end
        end
        SACP_CONV: begin
            st_d.step_cnt = st_q.step_cnt + 1'b1;
            if (st_q.step_cnt == STEP_CYC - 1'b1) begin
                st_d.step_cnt = '0;
                if (p.sar_cmp) begin
                    st_d.sar = st_q.sar | st_q.trial;
                end
                st_d.trial = st_q.trial >> 1;
                if (st_q.trial[0]) begin
                    st_d.state = SACP_PUSH;
                    st_d.hold = 1'b0;
                    st_d.acq_cnt = '0;
                end
            end
        end
        SACP_PUSH: begin
            if (fifo_in_ready) begin
                st_d.state = SACP_ACQ;
            end
        end
        default: begin
            st_d.state = SACP_ACQ;
        end
    endcase
    st_d.dac = st_d.sar | st_d.trial;

    // output shift register and serial port
    if (pop) begin
        st_d.word = fifo_out_data;
        st_d.shreg = fifo_out_data;
        st_d.sdo = fifo_out_data[`SACP_RES-1];
        st_d.bit_cnt = '0;
        st_d.loaded = 1'b1;
        st_d.div_cnt = '0;
        st_d.sclk_int = 1'b0;
        if (ext && rd_busy) begin
            st_d.ovr_cnt = OVR_CYC;
        end
    end else if (ext && !p.cs_n && sclk_rise && st_q.bit_cnt < RES_B) begin
        shift = 1'b1;
    end else if (st_q.sync) begin
        st_d.div_cnt = st_q.div_cnt + 1'b1;
        if (st_q.div_cnt == DIV_CYC - 1'b1) begin
            st_d.div_cnt = '0;
            st_d.sclk_int = !st_q.sclk_int;
            shift = st_q.sclk_int;
        end
    end else begin
        st_d.div_cnt = '0;
        st_d.sclk_int = 1'b0;
    end
    if (shift) begin
        st_d.shreg = st_q.shreg << 1;
        st_d.sdo = st_q.shreg[`SACP_RES-2];
        st_d.bit_cnt = st_q.bit_cnt + 1'b1;
    end
    st_d.sync = intser && bus_en && st_d.loaded && (st_d.bit_cnt < RES_B);
    st_d.flag = (st_d.ovr_cnt != '0);

    // busy covers conversion, queued result and the load into the shift register;
    // the push cycle counts too, as the FIFO shows the word only one edge later
    st_d.busy = (st_d.state != SACP_ACQ) || (st_q.state == SACP_PUSH) || start || !fifo_empty;
    st_d.pd = p.power_down_input && (st_q.state == SACP_ACQ) && fifo_empty;

    st_d.bus = '0;
    if (bus_en) begin
        st_d.bus.oe[`SACP_HI_MSB:`SACP_HI_LSB] = '1;
        st_d.bus.dout[`SACP_HI_MSB:`SACP_HI_LSB] = st_q.word[`SACP_HI_MSB:`SACP_HI_LSB];
        if (!ser) begin
            st_d.bus.oe = '1;
            st_d.bus.dout = st_q.word;
        end else begin
            st_d.bus.oe[`SACP_PIN_SDO] = 1'b1;
            st_d.bus.dout[`SACP_PIN_SDO] = st_q.sdo;
            if (intser) begin
                st_d.bus.oe[`SACP_PIN_SCLK] = 1'b1;
                st_d.bus.dout[`SACP_PIN_SCLK] = st_q.sclk_int;
                st_d.bus.oe[`SACP_PIN_SYNC] = 1'b1;
                st_d.bus.dout[`SACP_PIN_SYNC] = st_q.sync;
            end else begin
                st_d.bus.oe[`SACP_PIN_OVR] = 1'b1;
                st_d.bus.dout[`SACP_PIN_OVR] = st_q.flag;
            end
        end
    end

    // reset input aborts the conversion, clears busy, hold and the overrun flag, and drops queued results
    if (p.reset_pin) begin
        st_d.state = SACP_ACQ;
        st_d.hold = 1'b0;
        st_d.acq_cnt = '0;
        st_d.sar = '0;
        st_d.trial = '0;
        st_d.dac = '0;
        st_d.ovr_cnt = '0;
        st_d.flag = 1'b0;
        st_d.bit_cnt = '0;
        st_d.loaded = 1'b0;
        st_d.sync = 1'b0;
        st_d.busy = 1'b0;
    end
end

always_ff @(posedge clk_sys) begin
    if (!rstn) begin
        st_q <= ST_RST;
    end else begin
        st_q <= st_d;
    end
end

assign busy = st_q.busy;
assign sample_hold = st_q.hold;
assign power_reduced = st_q.pd;
assign dac_code = st_q.dac;
assign data_o = st_q.bus.dout;
assign data_oe = st_q.bus.oe;

default clocking cb @(posedge clk_sys);
endclocking
default disable iff (!rstn);

sequence s_ovr_event;
    ext && rd_busy && pop && !p.reset_pin;
endsequence

sequence s_flag_pulse;
    st_q.flag [*2];
endsequence

sequence s_conv_begin;
    start && !p.reset_pin;
endsequence

sequence s_conv_running;
    busy && sample_hold && (st_q.state == SACP_CONV);
endsequence

par_bit11_a: assert property (
    (bus_en && !ser) |=> (data_oe[`SACP_PIN_OVR] && data_o[`SACP_PIN_OVR] == $past(st_q.word[`SACP_PIN_OVR])))
    else $error("bit 11 not driven from result in parallel mode");

flag_pin_a: assert property (
    (bus_en && ext) |=> (data_oe[`SACP_PIN_OVR] && data_o[`SACP_PIN_OVR] == $past(st_q.flag)))
    else $error("shared pin does not show overrun flag");

ovr_pulse_a: assert property (
    s_ovr_event |=> s_flag_pulse)
    else $error("overrun flag not pulsed on lost read");

hi_bits_a: assert property (
    bus_en |=> (data_oe[`SACP_HI_MSB:`SACP_HI_LSB] == '1))
    else $error("upper result bits not driven");

bus_float_a: assert property (
    !bus_en |=> (data_oe == '0))
    else $error("bus driven without chip select and read");

conv_start_a: assert property (
    s_conv_begin |=> s_conv_running)
    else $error("busy or hold missing after start");

busy_hold_a: assert property (
    ((st_q.state != SACP_ACQ) || !fifo_empty) && !p.reset_pin |=> busy)
    else $error("busy dropped before result latched");

clk_gate_a: assert property (
    (ext && p.cs_n && !pop && !p.reset_pin) |=> $stable(st_q.bit_cnt))
    else $error("serial clock not gated by chip select");

reset_abort_a: assert property (
    p.reset_pin |=> (!busy && !sample_hold && st_q.state == SACP_ACQ && !st_q.flag))
    else $error("reset input did not abort");

pd_block_a: assert property (
    (p.power_down_input && st_q.state == SACP_ACQ) |=> (st_q.state == SACP_ACQ))
    else $error("conversion started in power-down");

impulse_go_a: assert property (
    (imp && acq_end && !p.convert_start_n && st_q.state == SACP_ACQ && !p.power_down_input && !p.reset_pin)
    |=> (st_q.state == SACP_CONV && sample_hold))
    else $error("impulse auto-start missed");

idle_flag_a: assert property (
    !st_q.loaded |-> !st_q.flag)
    else $error("overrun flag set before any result");

busy_fall_a: assert property (
    ($fell(busy) && !$past(p.reset_pin)) |-> (st_q.loaded && fifo_empty))
    else $error("busy fell before result reached shift register");

pd_idle_a: assert property (
    power_reduced |-> !busy)
    else $error("reduced power while busy");

int_pins_a: assert property (
    (bus_en && intser) |=> (data_oe[`SACP_PIN_SYNC:`SACP_PIN_SDO] == '1 && !data_oe[`SACP_PIN_OVR]))
    else $error("internal serial pins not driven");

endmodule : sacp_ctrl

// [sacp_defs.svh]
`ifndef SACP_DEFS_SVH
`define SACP_DEFS_SVH

// clock rate and times in ns
`define SACP_CLK_MHZ 200
`define SACP_ACQ_NS 250
`define SACP_STEP_NS 100
`define SACP_OVR_NS 10
// least time in ns to whole cycles, rounded up
`define SACP_CYC_UP(ns) (((ns) * `SACP_CLK_MHZ + 999) / 1000)

// widths and sizes
`define SACP_RES 16
`define SACP_CW 16
`define SACP_FIFO_DEPTH 8
`define SACP_SCLK_DIV 4

// shared pin positions on the result bus
`define SACP_PIN_SDO 8
`define SACP_PIN_SCLK 9
`define SACP_PIN_SYNC 10
`define SACP_PIN_OVR 11
`define SACP_HI_MSB 15
`define SACP_HI_LSB 12

`endif

// [sacp_fifo.sv]
`timescale 1ns/1ps
`include "sacp_defs.svh"

module sacp_fifo
    import sacp_pkg::*;
#(
    parameter int W = `SACP_RES,
    parameter int DEPTH = `SACP_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic empty
);

localparam int AW = $clog2(DEPTH);

typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
} sacp_fifo_st_t;

sacp_fifo_st_t st_q;
sacp_fifo_st_t st_d;

function automatic logic [AW-1:0] sacp_nxt(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
        return '0;
    end
    return AW'(p + 1'b1);
endfunction : sacp_nxt

assign in_ready = (st_q.cnt != (AW+1)'(DEPTH));
assign out_valid = st_q.ov;
assign out_data = st_q.od;
assign empty = (st_q.cnt == '0) && !st_q.ov;

always_comb begin
    logic push;
    logic pop;
    logic take;
    push = in_valid && in_ready;
    pop = st_q.ov && out_ready;
    take = (!st_q.ov || pop) && (st_q.cnt != '0);
    st_d = st_q;
    if (push) begin
        st_d.mem[st_q.wp] = in_data;
        st_d.wp = sacp_nxt(st_q.wp);
    end
    if (pop) begin
        st_d.ov = 1'b0;
    end
    // output stage is the registered read port
    if (take) begin
        st_d.od = st_q.mem[st_q.rp];
        st_d.ov = 1'b1;
        st_d.rp = sacp_nxt(st_q.rp);
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(take);
    if (clear) begin
        st_d.wp = '0;
        st_d.rp = '0;
        st_d.cnt = '0;
        st_d.ov = 1'b0;
    end
end

always_ff @(posedge clk_sys) begin
    if (!rstn) begin
        st_q <= '0;
    end else begin
        st_q <= st_d;
    end
end

endmodule : sacp_fifo

// [sacp_host_model.sv]
`timescale 1ns/1ps

module sacp_host_model
    import sacp_pkg::*;
(
    input wire logic run,
    input wire sacp_word_t dac_code,
    input wire sacp_word_t vin,
    input wire logic sdo,
    input wire logic sdo_en,
    output logic sclk_pin,
    output logic sar_cmp,
    output sacp_word_t rx,
    output int n_rise
);
    // comparator stand-in: keep the trial bit while the code stays at or below the input
    assign sar_cmp = (dac_code <= vin);

    initial begin
        sclk_pin = 1'b0;
        rx = '0;
        n_rise = 0;
    end

    // host clock runs only inside a frame; data is taken just before each rise
    // a quarter ns offset keeps every link edge off the clk_sys edges
    always begin
        wait (run);
        #0.25;
        while (run) begin
            #24;
            rx = {rx[14:0], sdo_en ? sdo : ~rx[0]};
            sclk_pin = 1'b1;
            n_rise = n_rise + 1;
            #24;
            sclk_pin = 1'b0;
        end
    end
endmodule : sacp_host_model

// [sacp_pkg.sv]
`include "sacp_defs.svh"

package sacp_pkg;

typedef logic [`SACP_RES-1:0] sacp_word_t;
typedef logic [`SACP_CW-1:0] sacp_cnt_t;
typedef logic [$clog2(`SACP_RES):0] sacp_bits_t;

// control pins and comparator, all from outside clk_sys
typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic reset_pin;
    logic power_down_input;
    logic serial_parallel_select;
    logic clock_source_select;
    logic impulse;
    logic warp;
    logic convert_start_n;
    logic sclk_pin;
    logic sar_cmp;
} sacp_pins_t;

typedef struct packed {
    sacp_word_t dout;
    sacp_word_t oe;
} sacp_bus_t;

typedef enum logic [1:0] {
    SACP_ACQ,
    SACP_CONV,
    SACP_PUSH
} sacp_state_t;

typedef struct packed {
    sacp_pins_t s1;
    sacp_pins_t s2;
    sacp_pins_t prev;
    sacp_state_t state;
    sacp_cnt_t acq_cnt;
    sacp_cnt_t step_cnt;
    sacp_cnt_t ovr_cnt;
    sacp_cnt_t div_cnt;
    sacp_word_t sar;
    sacp_word_t trial;
    sacp_word_t dac;
    sacp_word_t word;
    sacp_word_t shreg;
    sacp_bits_t bit_cnt;
    logic loaded;
    logic hold;
    logic busy;
    logic flag;
    logic sclk_int;
    logic sdo;
    logic sync;
    logic pd;
    sacp_bus_t bus;
} sacp_ctrl_st_t;

endpackage : sacp_pkg

// [test_sacp_ctrl.sv]
`timescale 1ns/1ps

module test_sacp_ctrl
    import sacp_pkg::*;
;
    logic clk_sys;
    logic rstn;
    sacp_pins_t ctl;
    sacp_pins_t pins;
    logic busy;
    logic sample_hold;
    logic power_reduced;
    sacp_word_t dac_code;
    sacp_word_t data_o;
    sacp_word_t data_oe;
    sacp_word_t vin;
    sacp_word_t rx;
    logic run;
    logic sclk_pin;
    logic sar_cmp;
    logic ovr_seen;
    int n_rise;
    int error_cnt;
    int n_compared;
    logic sck_q;
    sacp_word_t irx;
    int n_irx;
    int n_start;

    sacp_ctrl u_dut (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pins(pins),
        .busy(busy),
        .sample_hold(sample_hold),
        .power_reduced(power_reduced),
        .dac_code(dac_code),
        .data_o(data_o),
        .data_oe(data_oe)
    );

    sacp_host_model u_host (
        .run(run),
        .dac_code(dac_code),
        .vin(vin),
        .sdo(data_o[8]),
        .sdo_en(data_oe[8]),
        .sclk_pin(sclk_pin),
        .sar_cmp(sar_cmp),
        .rx(rx),
        .n_rise(n_rise)
    );

    always #2.5 clk_sys = ~clk_sys;

    always_comb begin
        pins = ctl;
        pins.sclk_pin = sclk_pin;
        pins.sar_cmp = sar_cmp;
    end

    always @(posedge clk_sys) begin
        if (data_oe[11] === 1'b1 && data_o[11] === 1'b1) begin
            ovr_seen = 1'b1;
        end
    end

    // collects the internal-clock serial word on each rise of the driven clock pin
    always @(posedge clk_sys) begin
        sck_q <= data_oe[9] && data_o[9];
        if (data_oe[9] && data_o[9] && !sck_q) begin
            irx <= {irx[14:0], data_o[8]};
            n_irx <= n_irx + 1;
        end
    end

    task close_out;
        $display("compared %0d, wrong %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    task chk_w(input sacp_word_t got, input sacp_word_t exp, input string m);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h", $time, m, got);
        end
    endtask : chk_w

    task chk_b(input logic got, input logic exp, input string m);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %b", $time, m, got);
        end
    endtask : chk_b

    function automatic logic pick(input int sel);
        return (sel == 0) ? busy : power_reduced;
    endfunction : pick

    task wait_for(input int sel, input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim && pick(sel) !== lvl; i++) step(1);
        if (pick(sel) !== lvl) begin
            error_cnt++;
            $display("wrong value at %0t: wait ran out", $time);
            close_out();
        end
    endtask : wait_for

    task sread(input int n);
        int i;
        int t;
        t = n_rise + n;
        run = 1'b1;
        for (i = 0; i < 12 * n + 20 && n_rise < t; i++) step(1);
        run = 1'b0;
        step(12);
        chk_b(n_rise == t, 1'b1, "serial clock count");
    endtask : sread

    task start_conv(input sacp_word_t v);
        vin = v;
        step(60);
        ctl.convert_start_n = 1'b0;
        wait_for(0, 1'b1, 8);
        chk_b(sample_hold, 1'b1, "sample hold");
        ctl.convert_start_n = 1'b1;
    endtask : start_conv

    task end_conv(input sacp_word_t v);
        step(300);
        chk_b(busy, 1'b1, "busy early fall");
        wait_for(0, 1'b0, 400);
        step(1);
        chk_b(busy, 1'b0, "busy fell once");
        chk_w(dac_code, v, "result code");
    endtask : end_conv

    initial begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        ctl = '0;
        ctl.cs_n = 1'b1;
        ctl.rd_n = 1'b1;
        ctl.convert_start_n = 1'b1;
        run = 1'b0;
        vin = '0;
        ovr_seen = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        step(2);
        rstn = 1'b1;
        step(2);
        chk_b(busy, 1'b0, "busy after reset");
        chk_w(data_oe, 16'h0000, "enables after reset");
        $display("test reset done");

        start_conv(16'h9a5c);
        end_conv(16'h9a5c);
        ctl.rd_n = 1'b0;
        step(4);
        chk_w(data_oe, 16'h0000, "read without select");
        ctl.cs_n = 1'b0;
        step(4);
        chk_w(data_oe, 16'hffff, "parallel enables");
        chk_w(data_o, 16'h9a5c, "parallel word");
        ctl.cs_n = 1'b1;
        ctl.rd_n = 1'b1;
        step(4);
        chk_w(data_oe, 16'h0000, "bus released");
        $display("test parallel done");

        ctl.serial_parallel_select = 1'b1;
        ctl.clock_source_select = 1'b1;
        ctl.rd_n = 1'b0;
        start_conv(16'h36c9);
        end_conv(16'h36c9);
        sread(3);
        ctl.cs_n = 1'b0;
        step(4);
        chk_w(data_o & 16'hf000, 16'h3000, "high bits in serial");
        chk_b(data_oe[11], 1'b1, "flag pin driven");
        sread(16);
        chk_w(rx, 16'h36c9, "serial word");
        ovr_seen = 1'b0;
        start_conv(16'h5e17);
        end_conv(16'h5e17);
        step(4);
        chk_b(ovr_seen, 1'b0, "flag after full read");
        sread(5);
        start_conv(16'hc3a1);
        end_conv(16'hc3a1);
        step(4);
        chk_b(ovr_seen, 1'b1, "flag after short read");
        sread(16);
        chk_w(rx, 16'hc3a1, "replaced word");
        ctl.cs_n = 1'b1;
        ctl.rd_n = 1'b1;
        ctl.clock_source_select = 1'b0;
        start_conv(16'ha5c3);
        end_conv(16'ha5c3);
        n_start = n_irx;
        ctl.cs_n = 1'b0;
        ctl.rd_n = 1'b0;
        step(20);
        chk_w(data_oe, 16'hf700, "internal serial enables");
        chk_b(data_o[10], 1'b1, "frame sync high");
        step(160);
        chk_b(n_irx - n_start == 16, 1'b1, "internal clock count");
        chk_w(irx, 16'ha5c3, "internal serial word");
        chk_b(data_o[10], 1'b0, "frame sync low");
        ctl.cs_n = 1'b1;
        ctl.rd_n = 1'b1;
        ctl.serial_parallel_select = 1'b0;
        $display("test serial done");

        ctl.impulse = 1'b1;
        start_conv(16'h7001);
        end_conv(16'h7001);
        ctl.convert_start_n = 1'b0;
        wait_for(0, 1'b1, 70);
        ctl.convert_start_n = 1'b1;
        end_conv(16'h7001);
        ctl.warp = 1'b1;
        ctl.convert_start_n = 1'b0;
        step(70);
        chk_b(busy, 1'b0, "no auto start in warp");
        ctl.convert_start_n = 1'b1;
        ctl.warp = 1'b0;
        ctl.impulse = 1'b0;
        $display("test impulse done");

        start_conv(16'h1234);
        step(100);
        ctl.reset_pin = 1'b1;
        wait_for(0, 1'b0, 6);
        chk_b(sample_hold, 1'b0, "hold after abort");
        ctl.reset_pin = 1'b0;
        $display("test abort done");

        start_conv(16'hbeef);
        step(10);
        ctl.power_down_input = 1'b1;
        end_conv(16'hbeef);
        wait_for(1, 1'b1, 20);
        ctl.convert_start_n = 1'b0;
        step(20);
        chk_b(busy, 1'b0, "start in power down");
        ctl.convert_start_n = 1'b1;
        ctl.power_down_input = 1'b0;
        step(4);
        $display("test power down done");
        close_out();
    end
endmodule : test_sacp_ctrl
